// ===== flash_rewrite_control.sv
// flash rewrite sequencer with axi4-lite registers and programmer port
`timescale 1ns/1ps
`include "frc_defs.svh"

// Function
// - flash changes only by two commands; byte program, whole-block erase
// - serial mode checks id unless three reset-vector bytes read ffffffh
// - id compared with seven stored bytes; mismatch refuses all commands
// - protect select 0 and release 1 block parallel reads and writes
// - protection cleared by cpu or serial erase of option block, or by programming release bit to 0
// - erased option block makes option byte read ffh
// - after cpu program or erase: status mode in ram mode, array in rom
// - rom mode refuses rewrite of program blocks and read-status command
// - rom mode stalls cpu and holds ports during operation; ram runs
// - ready and error bits in control reg; status reg in ram mode
// - boot rom separate at same addresses; only user rom rewritable
// - cpu commands accepted only with rewrite enable; select 0 is ram mode
// - select bit 1 puts device in rom-execution rewrite mode
// - ready reads 0 during program or erase, 1 otherwise
// - program error flags failed programming; both errors: sequence error
module flash_rewrite_control #(
  parameter int          AW         = 8,
  parameter logic [15:0] PROG_CYCLES  = `FRC_PROG_CYC,
  parameter logic [15:0] ERASE_CYCLES = `FRC_ERASE_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // axi4-lite write
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  output logic [1:0]       s_bresp,
  // axi4-lite read
  input  wire logic        s_arvalid,
  output logic             s_arready,
  input  wire logic [7:0]  s_araddr,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  // external programmer
  input  wire logic [1:0]  pgmMode,
  input  wire logic        pgmValid,
  output logic             pgmReady,
  input  wire logic [2:0]  pgmCmd,
  input  wire logic [15:0] pgmAddr,
  input  wire logic [7:0]  pgmData,
  output logic             pgmDone,
  output logic             pgmRefused,
  output logic [7:0]       pgmRdData,
  input  wire logic        idValid,
  input  wire logic [7:0]  idByte,
  // cpu side effects
  output logic             cpuStall,
  output logic             ioHold,
  output logic             irq
);

  localparam int DEPTH = 1 << AW;
  localparam int BW    = 2;

  frc_pkg::frc_state_s q, d;
  logic [7:0]  mem [DEPTH];
  logic        startOp, timerBusy, timerDone, memWe, memErase;
  logic        wrGo, cReq, cCpu, refuse, seqErr, vecBlank, protActive;
  logic [2:0]  ev, clr;
  logic [15:0] cAddr;
  logic [7:0]  cData, optByte, statusReg, rdByte, idRef;
  logic [BW-1:0] cBlk;
  frc_pkg::frc_cmd_e cOp;
  logic        flashReady;

  ////////////////////////////////////////////////////////////////////////////
  // operation timer and flash array

  frc_op_timer u_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .start   (startOp),
    .cycles  ((cOp == frc_pkg::FRC_CMD_PROG) ? PROG_CYCLES : ERASE_CYCLES),
    .busy    (timerBusy),
    .done    (timerDone)
  );

  // nonvolatile: no reset; erase first to get defined contents
  always_ff @(posedge clk_sys) begin
    if (memWe) begin
      mem[q.addr[AW-1:0]] <= mem[q.addr[AW-1:0]] & q.data;
    end
    if (memErase) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (i[AW-1 -: BW] == q.addr[AW-1 -: BW]) begin
          mem[i] <= `FRC_ERASED;
        end
      end
    end
  end

  // fixed addresses fold into the array, same as command addresses
  assign optByte  = mem[AW'(`FRC_OPT_ADDR)];
  assign vecBlank = (mem[AW'(`FRC_VEC_LO)] == `FRC_ERASED) &&
                    (mem[AW'(`FRC_VEC_MID)] == `FRC_ERASED) &&
                    (mem[AW'(`FRC_VEC_HI)] == `FRC_ERASED);
  assign protActive = !optByte[`FRC_OPT_SEL] && optByte[`FRC_OPT_REL];
  assign idRef      = mem[AW'(`FRC_ID_BASE) + AW'(q.idIdx)];
  assign flashReady = (q.state == frc_pkg::FRC_IDLE);
  assign statusReg  = {flashReady, 1'b0, q.eraseErr, q.progErr, 4'h0};

  ////////////////////////////////////////////////////////////////////////////
  // command source selection

  assign s_awready = !q.awHave;
  assign s_wready  = !q.wHave;
  assign s_arready = !q.rvalid;
  assign wrGo      = q.awHave && q.wHave && !q.bvalid;
  assign pgmReady  = flashReady && (pgmMode != frc_pkg::FRC_PM_CPU);

  always_comb begin
    cReq  = 1'b0;
    cCpu  = 1'b0;
    cOp   = frc_pkg::frc_cmd_e'(pgmCmd);
    cAddr = pgmAddr;
    cData = pgmData;
    // programmer first: its handshake is already taken at this edge
    if (pgmValid && pgmReady) begin
      cReq = 1'b1;
    end else if (wrGo && q.awAddr == `FRC_REG_CMD && q.wStrb == 4'hf) begin
      cCpu  = 1'b1;
      cOp   = frc_pkg::frc_cmd_e'(q.wData[2:0]);
      cAddr = q.wData[31:16];
      cData = q.wData[15:8];
      // cpu commands need rewrite enable and no programmer attached
      cReq  = q.cpuEn && (pgmMode == frc_pkg::FRC_PM_CPU);
    end
    cBlk   = cAddr[AW-1 -: BW];
    refuse = (cCpu && !flashReady) ||
             (!cCpu && pgmMode == frc_pkg::FRC_PM_SERIAL &&
              !vecBlank && !q.idOk) ||
             (!cCpu && pgmMode == frc_pkg::FRC_PM_PAR && protActive);
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d         = q;
    d.pgmDone = 1'b0;
    d.pgmRef  = 1'b0;
    startOp   = 1'b0;
    memWe     = 1'b0;
    memErase  = 1'b0;
    seqErr    = 1'b0;
    ev        = 3'h0;
    clr       = 3'h0;
    rdByte    = q.bootView ? `FRC_BOOT_FILL : mem[q.faddr[AW-1:0]];

    // axi write channels, either order
    if (s_awvalid && !q.awHave) begin
      d.awHave = 1'b1;
      d.awAddr = s_awaddr;
    end
    if (s_wvalid && !q.wHave) begin
      d.wHave = 1'b1;
      d.wData = s_wdata;
      d.wStrb = s_wstrb;
    end
    if (q.bvalid && s_bready) begin
      d.bvalid = 1'b0;
    end
    if (wrGo) begin
      d.awHave = 1'b0;
      d.wHave  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = 2'b00;
      case (q.awAddr)
        `FRC_REG_FCRA: begin
          if (q.wStrb[0]) begin
            d.cpuEn = q.wData[`FRC_FCRA_ENABLE];
          end
        end
        `FRC_REG_MODE: begin
          if (q.wStrb[0]) begin
            d.modeSel   = q.wData[`FRC_MODE_SEL];
            d.bootView  = q.wData[`FRC_MODE_BOOT];
            d.blockMask = q.wData[`FRC_MODE_MASK +: 4];
          end
        end
        `FRC_REG_CMD: begin
          if (!(cReq && cCpu)) begin
            ev[`FRC_IRQ_REF] = 1'b1;
          end
        end
        `FRC_REG_FADDR: begin
          if (q.wStrb[0]) begin
            d.faddr[7:0] = q.wData[7:0];
          end
          if (q.wStrb[1]) begin
            d.faddr[15:8] = q.wData[15:8];
          end
        end
        `FRC_REG_IRQS: begin
          if (q.wStrb[0]) begin
            clr = q.wData[2:0];
          end
        end
        `FRC_REG_IRQM: begin
          if (q.wStrb[0]) begin
            d.irqMask = q.wData[2:0];
          end
        end
        `FRC_REG_RDATA, `FRC_REG_INFO: begin
        end
        default: begin
          d.bresp = 2'b10;
        end
      endcase
    end

    // axi read channel
    if (q.rvalid && s_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp  = 2'b00;
      case (s_araddr)
        `FRC_REG_FCRA:  d.rdata = {24'h0, q.eraseErr, q.progErr, 4'h0,
                                   q.cpuEn, flashReady};
        `FRC_REG_MODE:  d.rdata = {24'h0, q.blockMask, 1'b0, q.bootView,
                                   q.modeSel, 1'b0};
        `FRC_REG_CMD:   d.rdata = 32'h0;
        `FRC_REG_RDATA: d.rdata = {24'h0, q.readStat ? statusReg : rdByte};
        `FRC_REG_FADDR: d.rdata = {16'h0, q.faddr};
        `FRC_REG_IRQS:  d.rdata = {29'h0, q.irqStat};
        `FRC_REG_IRQM:  d.rdata = {29'h0, q.irqMask};
        `FRC_REG_INFO:  d.rdata = {28'h0, optByte == `FRC_ERASED, vecBlank,
                                   q.idOk, protActive};
        default: begin
          d.rdata = 32'h0;
          d.rresp = 2'b10;
        end
      endcase
    end

    // id code sequence from the serial programmer
    if (idValid) begin
      d.idIdx = (q.idIdx == `FRC_ID_LEN - 3'h1) ? 3'h0 : q.idIdx + 3'h1;
      d.idMis = (q.idIdx == 3'h0) ? (idByte != idRef) : (q.idMis || idByte != idRef);
      if (q.idIdx == `FRC_ID_LEN - 3'h1) begin
        d.idOk  = !(q.idMis || idByte != idRef);
        d.idMis = 1'b0;
      end
    end

    // command dispatch
    if (cReq && refuse) begin
      ev[`FRC_IRQ_REF] = 1'b1;
      d.pgmRef         = !cCpu;
    end else if (cReq) begin
      d.pgmDone = !cCpu;
      case (cOp)
        frc_pkg::FRC_CMD_PROG, frc_pkg::FRC_CMD_ERASE: begin
          if (cCpu && q.modeSel && q.blockMask[cBlk]) begin
            seqErr = 1'b1;
          end else begin
            d.state    = frc_pkg::FRC_BUSY;
            d.op       = cOp;
            d.addr     = cAddr;
            d.data     = cData;
            d.srcCpu   = cCpu;
            d.progErr  = 1'b0;
            d.eraseErr = 1'b0;
            d.pgmDone  = 1'b0;
            startOp    = 1'b1;
          end
        end
        frc_pkg::FRC_CMD_RDARR: begin
          d.readStat = 1'b0;
          d.pgmRd    = mem[cAddr[AW-1:0]];
        end
        frc_pkg::FRC_CMD_RDSTAT: begin
          if (cCpu && q.modeSel) begin
            seqErr = 1'b1;
          end else begin
            d.readStat = 1'b1;
            d.pgmRd    = statusReg;
          end
        end
        frc_pkg::FRC_CMD_CLRST: begin
          d.progErr  = 1'b0;
          d.eraseErr = 1'b0;
        end
        default: begin
          seqErr = 1'b1;
        end
      endcase
    end
    if (seqErr) begin
      d.progErr        = 1'b1;
      d.eraseErr       = 1'b1;
      ev[`FRC_IRQ_ERR] = 1'b1;
    end

    // completion of an automatic operation
    if (q.state == frc_pkg::FRC_BUSY && timerDone) begin
      d.state         = frc_pkg::FRC_IDLE;
      d.pgmDone       = !q.srcCpu;
      ev[`FRC_IRQ_DONE] = 1'b1;
      if (q.op == frc_pkg::FRC_CMD_PROG) begin
        memWe = 1'b1;
        // flash can only clear bits: a one over a zero fails verify
        if ((mem[q.addr[AW-1:0]] & q.data) != q.data) begin
          d.progErr        = 1'b1;
          ev[`FRC_IRQ_ERR] = 1'b1;
        end
      end else begin
        memErase = 1'b1;
      end
      if (q.srcCpu) begin
        d.readStat = !q.modeSel;
      end
    end
    if (q.state == frc_pkg::FRC_BUSY && !timerBusy && !startOp && !timerDone) begin
      d.state = frc_pkg::FRC_IDLE;
    end

    // set wins over a same-cycle clear
    d.irqStat = (q.irqStat & ~clr) | ev;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign s_bvalid   = q.bvalid;
  assign s_bresp    = q.bresp;
  assign s_rvalid   = q.rvalid;
  assign s_rdata    = q.rdata;
  assign s_rresp    = q.rresp;
  assign pgmDone    = q.pgmDone;
  assign pgmRefused = q.pgmRef;
  assign pgmRdData  = q.pgmRd;
  assign cpuStall   = !flashReady && q.srcCpu && q.modeSel;
  assign ioHold     = cpuStall;
  assign irq        = |(q.irqStat & q.irqMask);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_ready_drops: assert property (
    startOp |=> !flashReady ##1 !flashReady)
    else $error("ready not low after operation start");

  a_ram_status_mode: assert property (
    (timerDone && !flashReady && q.srcCpu && !q.modeSel) |=> q.readStat)
    else $error("ram mode did not enter status read mode");

  a_rom_array_mode: assert property (
    (timerDone && !flashReady && q.srcCpu && q.modeSel) |=> !q.readStat)
    else $error("rom mode did not enter array read mode");

  a_cpu_stall_rom: assert property (
    (startOp && cCpu && q.modeSel) |=> cpuStall && ioHold)
    else $error("cpu not stalled in rom mode operation");

  a_ram_no_stall: assert property (
    !q.modeSel |-> !cpuStall)
    else $error("cpu stalled in ram mode");

  a_parallel_protect: assert property (
    (cReq && !cCpu && pgmMode == frc_pkg::FRC_PM_PAR && protActive)
      |=> pgmRefused && flashReady)
    else $error("parallel command passed protection");

  a_id_refuse: assert property (
    (pgmValid && pgmReady && pgmMode == frc_pkg::FRC_PM_SERIAL &&
     !vecBlank && !q.idOk) |=> pgmRefused && !pgmDone)
    else $error("serial command taken without id match");

  a_rom_block_guard: assert property (
    (cReq && !refuse && cCpu && q.modeSel && q.blockMask[cBlk] &&
     (cOp == frc_pkg::FRC_CMD_PROG || cOp == frc_pkg::FRC_CMD_ERASE))
      |=> q.progErr && q.eraseErr && flashReady)
    else $error("program block rewritten in rom mode");

  a_enable_gate: assert property (
    (wrGo && q.awAddr == `FRC_REG_CMD && !q.cpuEn) |-> !(startOp && cCpu))
    else $error("command accepted with rewrite disabled");

  a_status_mirror: assert property (
    statusReg[`FRC_SR_READY] == flashReady &&
    statusReg[`FRC_SR_PERR] == q.progErr &&
    statusReg[`FRC_SR_EERR] == q.eraseErr)
    else $error("status register does not mirror control register");

endmodule : flash_rewrite_control

// ===== frc_defs.svh
// offsets, field positions, codes and counts of the flash rewrite control
`ifndef FRC_DEFS_SVH
`define FRC_DEFS_SVH

// register byte offsets
`define FRC_REG_FCRA    8'h00
`define FRC_REG_MODE    8'h04
`define FRC_REG_CMD     8'h08
`define FRC_REG_RDATA   8'h0c
`define FRC_REG_FADDR   8'h10
`define FRC_REG_IRQS    8'h14
`define FRC_REG_IRQM    8'h18
`define FRC_REG_INFO    8'h1c

// flash_control_reg_a fields
`define FRC_FCRA_READY  0
`define FRC_FCRA_ENABLE 1
`define FRC_FCRA_PERR   6
`define FRC_FCRA_EERR   7

// mode register fields
`define FRC_MODE_SEL    1
`define FRC_MODE_BOOT   2
`define FRC_MODE_MASK   4

// status register fields
`define FRC_SR_READY    7
`define FRC_SR_EERR     5
`define FRC_SR_PERR     4

// option_select_byte fields
`define FRC_OPT_SEL     3
`define FRC_OPT_REL     2

// flash addresses
`define FRC_VEC_LO      16'hfffc
`define FRC_VEC_MID     16'hfffd
`define FRC_VEC_HI      16'hfffe
`define FRC_ID_BASE     16'hffe0
`define FRC_ID_LEN      3'h7
`define FRC_OPT_ADDR    16'hffff
`define FRC_ERASED      8'hff

// interrupt status bits
`define FRC_IRQ_DONE    0
`define FRC_IRQ_ERR     1
`define FRC_IRQ_REF     2

// operation lengths in clock cycles, and boot rom fill byte
`define FRC_PROG_CYC    16'h0010
`define FRC_ERASE_CYC   16'h0040
`define FRC_BOOT_FILL   8'h00

`endif

// ===== frc_pkg.sv
// types shared by the flash rewrite control
package frc_pkg;

  typedef enum logic [0:0] {
    FRC_IDLE = 1'b0,
    FRC_BUSY = 1'b1
  } frc_state_e;

  typedef enum logic [2:0] {
    FRC_CMD_NONE   = 3'b000,
    FRC_CMD_PROG   = 3'b001,
    FRC_CMD_ERASE  = 3'b010,
    FRC_CMD_RDARR  = 3'b011,
    FRC_CMD_RDSTAT = 3'b100,
    FRC_CMD_CLRST  = 3'b101
  } frc_cmd_e;

  typedef enum logic [1:0] {
    FRC_PM_CPU    = 2'b00,
    FRC_PM_SERIAL = 2'b01,
    FRC_PM_PAR    = 2'b10
  } frc_pmode_e;

  typedef struct packed {
    logic [15:0] cnt;
    logic        busy;
    logic        done;
  } frc_timer_s;

  typedef struct packed {
    frc_state_e  state;
    frc_cmd_e    op;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        srcCpu;
    logic        cpuEn;
    logic        modeSel;
    logic        bootView;
    logic [3:0]  blockMask;
    logic [15:0] faddr;
    logic        readStat;
    logic        progErr;
    logic        eraseErr;
    logic [2:0]  irqStat;
    logic [2:0]  irqMask;
    logic [2:0]  idIdx;
    logic        idMis;
    logic        idOk;
    logic        awHave;
    logic [7:0]  awAddr;
    logic        wHave;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        pgmDone;
    logic        pgmRef;
    logic [7:0]  pgmRd;
  } frc_state_s;

endpackage : frc_pkg

// ===== frc_op_timer.sv
// down-counter timing one automatic program or erase operation
`timescale 1ns/1ps
module frc_op_timer (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // control
  input  wire logic        start,
  input  wire logic [15:0] cycles,
  // state
  output logic             busy,
  output logic             done
);

  frc_pkg::frc_timer_s q, d;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (start) begin
      d.cnt  = cycles;
      d.busy = 1'b1;
    end else if (q.busy) begin
      if (q.cnt <= 16'h0001) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;
  assign done = q.done;

endmodule : frc_op_timer

// ===== frc_prog_model.sv
// external programmer model for the flash rewrite control
`timescale 1ns/1ps
////////////////////////////////////////
module frc_prog_model (
  // clock
  input  wire logic        clk_sys,
  // command handshake
  output logic             pgmValid,
  input  wire logic        pgmReady,
  output logic [2:0]       pgmCmd,
  output logic [15:0]      pgmAddr,
  output logic [7:0]       pgmData,
  input  wire logic        pgmDone,
  input  wire logic        pgmRefused,
  // id bytes
  output logic             idValid,
  output logic [7:0]       idByte
);
  initial begin
    pgmValid = 1'b0;
    pgmCmd   = 3'h0;
    pgmAddr  = 16'h0000;
    pgmData  = 8'h00;
    idValid  = 1'b0;
    idByte   = 8'h00;
  end
  ////////////////////////////////////////
  // res is {refused, done}; 00 means no answer came
  task automatic issue(input logic [2:0] c, input logic [15:0] a,
                       input logic [7:0] d, output logic [1:0] res);
    int n;
    pgmValid <= 1'b1;
    pgmCmd   <= c;
    pgmAddr  <= a;
    pgmData  <= d;
    n = 0;
    do begin @(negedge clk_sys); n++; end
      while (pgmReady !== 1'b1 && n < 300);
    @(posedge clk_sys);
    pgmValid <= 1'b0;
    // released lines must not keep looking valid
    pgmAddr  <= ~a;
    pgmData  <= ~d;
    n = 0;
    do begin @(negedge clk_sys); n++; end
      while (pgmDone !== 1'b1 && pgmRefused !== 1'b1 && n < 300);
    res = {pgmRefused, pgmDone};
    @(posedge clk_sys);
  endtask : issue

  // seven one-cycle id strobes, gaps between them
  task automatic sendId(input logic [7:0] b);
    repeat (7) begin
      idValid <= 1'b1;
      idByte  <= b;
      @(posedge clk_sys);
      idValid <= 1'b0;
      idByte  <= ~b;
      @(posedge clk_sys);
    end
  endtask : sendId
endmodule : frc_prog_model

// ===== flash_rewrite_control_test.sv
// self-checking bench for the flash rewrite control
`timescale 1ns/1ps
`include "frc_defs.svh"
`define FRC_CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin \
  fails++; $display("mismatch at %0t got %h exp %h", $time, g, e); end end
////////////////////////////////////////
module flash_rewrite_control_test;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] b;
    logic [7:0] f;
  } frc_row_s;
  logic        clk_sys, rst_n, s_awvalid, s_awready, s_wvalid, s_wready;
  logic        s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid;
  logic        s_rready, pgmValid, pgmReady, pgmDone, pgmRefused;
  logic        idValid, cpuStall, ioHold, irq;
  logic [7:0]  s_awaddr, s_araddr, pgmData, pgmRdData, idByte;
  logic [31:0] s_wdata, s_rdata, v;
  logic [3:0]  s_wstrb;
  logic [2:0]  pgmCmd;
  logic [15:0] pgmAddr;
  logic [1:0]  s_bresp, s_rresp, pgmMode, r, res, br;
  int          fails, samplesChecked;
  // addr, data, byte after, control a after
  frc_row_s    rows [3] = '{'{8'h10, 8'ha5, 8'ha5, 8'h03},
                            '{8'h10, 8'h5a, 8'h00, 8'h43},
                            '{8'h3f, 8'h00, 8'h00, 8'h03}};

  always #5 clk_sys = ~clk_sys;

  flash_rewrite_control i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_awaddr(s_awaddr),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_bresp(s_bresp), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_araddr(s_araddr), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .pgmMode(pgmMode),
    .pgmValid(pgmValid), .pgmReady(pgmReady), .pgmCmd(pgmCmd),
    .pgmAddr(pgmAddr), .pgmData(pgmData), .pgmDone(pgmDone),
    .pgmRefused(pgmRefused), .pgmRdData(pgmRdData), .idValid(idValid),
    .idByte(idByte), .cpuStall(cpuStall), .ioHold(ioHold), .irq(irq));

  frc_prog_model i_pgm (.clk_sys(clk_sys), .pgmValid(pgmValid),
    .pgmReady(pgmReady), .pgmCmd(pgmCmd), .pgmAddr(pgmAddr),
    .pgmData(pgmData), .pgmDone(pgmDone), .pgmRefused(pgmRefused),
    .idValid(idValid), .idByte(idByte));
  ////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic tmo;
    fails++;
    give_verdict();
  endtask : tmo

  // ready is judged at the falling edge, acted on at the next rising one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic ta, tw, da, dw;
    s_awvalid <= 1'b1;
    s_awaddr  <= a;
    s_wvalid  <= 1'b1;
    s_wdata   <= d;
    {n, da, dw} = '0;
    do begin
      @(negedge clk_sys);
      ta = s_awvalid & s_awready;
      tw = s_wvalid & s_wready;
      @(posedge clk_sys);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
      n++;
    end while (!(da & dw) && n < 50);
    do begin @(negedge clk_sys); n++; end
      while (s_bvalid !== 1'b1 && n < 100);
    br = s_bresp;
    @(posedge clk_sys);
    if (n >= 100) tmo();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] rr);
    int n;
    s_arvalid <= 1'b1;
    s_araddr  <= a;
    n = 0;
    do begin @(negedge clk_sys); n++; end
      while (s_arready !== 1'b1 && n < 50);
    @(posedge clk_sys);
    s_arvalid <= 1'b0;
    do begin @(negedge clk_sys); n++; end
      while (s_rvalid !== 1'b1 && n < 100);
    d  = s_rdata;
    rr = s_rresp;
    @(posedge clk_sys);
    if (n >= 100) tmo();
  endtask : rd

  task automatic cmd(input logic [2:0] op, input logic [15:0] a,
                     input logic [7:0] d);
    wr(`FRC_REG_CMD, {a, d, 5'h00, op});
  endtask : cmd

  task automatic waitRdy;
    int          n;
    logic [31:0] x;
    logic [1:0]  y;
    n = 0;
    do begin rd(`FRC_REG_FCRA, x, y); n++; end
      while (x[0] !== 1'b1 && n < 60);
    if (n >= 60) tmo();
  endtask : waitRdy
  ////////////////////////////////////////
  initial begin
    {clk_sys, rst_n, s_awvalid, s_wvalid, s_arvalid} = '0;
    {s_awaddr, s_araddr, s_wdata, pgmMode} = '0;
    {s_bready, s_rready, s_wstrb} = 6'h3f;
    {fails, samplesChecked} = '0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`FRC_REG_FCRA, v, r);
    `FRC_CHK(v, 32'h00000001)
    rd(8'h20, v, r);
    `FRC_CHK(r, 2'b10)
    wr(8'h20, 32'h0);
    `FRC_CHK(br, 2'b10)
    wr(`FRC_REG_FCRA, 32'h2);
    for (int b = 0; b < 4; b++) begin
      cmd(frc_pkg::FRC_CMD_ERASE, 16'(b * 64), 8'h00);
      waitRdy();
    end
    rd(`FRC_REG_RDATA, v, r);
    `FRC_CHK(v, 32'h00000080)
    rd(`FRC_REG_INFO, v, r);
    `FRC_CHK(v[3:0], 4'hc)
    foreach (rows[i]) begin
      cmd(frc_pkg::FRC_CMD_CLRST, 16'h0000, 8'h00);
      cmd(frc_pkg::FRC_CMD_PROG, {8'h00, rows[i].a}, rows[i].d);
      @(negedge clk_sys);
      `FRC_CHK({cpuStall, ioHold}, 2'b00)
      @(posedge clk_sys);
      waitRdy();
      rd(`FRC_REG_FCRA, v, r);
      `FRC_CHK(v, {24'h0, rows[i].f})
      rd(`FRC_REG_RDATA, v, r);
      `FRC_CHK(v[7:0], {2'b10, rows[i].f[7:6], 4'h0})
      cmd(frc_pkg::FRC_CMD_RDARR, 16'h0000, 8'h00);
      wr(`FRC_REG_FADDR, {24'h0, rows[i].a});
      rd(`FRC_REG_RDATA, v, r);
      `FRC_CHK(v[7:0], rows[i].b)
    end
    wr(`FRC_REG_IRQM, 32'h1);
    @(negedge clk_sys);
    `FRC_CHK(irq, 1'b1)
    @(posedge clk_sys);
    wr(`FRC_REG_IRQS, 32'h7);
    wr(`FRC_REG_FCRA, 32'h0);
    cmd(frc_pkg::FRC_CMD_PROG, 16'h0020, 8'h00);
    wr(`FRC_REG_IRQM, 32'h4);
    @(negedge clk_sys);
    `FRC_CHK(irq, 1'b1)
    @(posedge clk_sys);
    rd(`FRC_REG_FCRA, v, r);
    `FRC_CHK(v, 32'h00000001)
    wr(`FRC_REG_IRQM, 32'h0);
    @(negedge clk_sys);
    `FRC_CHK(irq, 1'b0)
    @(posedge clk_sys);
    wr(`FRC_REG_IRQS, 32'h7);
    // rom-execution mode, block 0 marked as holding the program
    wr(`FRC_REG_FCRA, 32'h2);
    wr(`FRC_REG_MODE, 32'h12);
    cmd(frc_pkg::FRC_CMD_PROG, 16'h0005, 8'h00);
    waitRdy();
    rd(`FRC_REG_FCRA, v, r);
    `FRC_CHK(v, 32'h000000c3)
    cmd(frc_pkg::FRC_CMD_CLRST, 16'h0000, 8'h00);
    cmd(frc_pkg::FRC_CMD_PROG, 16'h0050, 8'h3c);
    @(negedge clk_sys);
    `FRC_CHK({cpuStall, ioHold}, 2'b11)
    @(posedge clk_sys);
    waitRdy();
    wr(`FRC_REG_FADDR, 32'h50);
    rd(`FRC_REG_RDATA, v, r);
    `FRC_CHK(v[7:0], 8'h3c)
    wr(`FRC_REG_MODE, 32'h16);
    rd(`FRC_REG_RDATA, v, r);
    `FRC_CHK(v[7:0], 8'h00)
    cmd(frc_pkg::FRC_CMD_RDSTAT, 16'h0000, 8'h00);
    rd(`FRC_REG_FCRA, v, r);
    `FRC_CHK(v, 32'h000000c3)
    cmd(frc_pkg::FRC_CMD_CLRST, 16'h0000, 8'h00);
    wr(`FRC_REG_MODE, 32'h0);
    // serial programmer, vector no longer blank
    cmd(frc_pkg::FRC_CMD_PROG, 16'hfffc, 8'h00);
    waitRdy();
    pgmMode <= 2'b01;
    i_pgm.issue(frc_pkg::FRC_CMD_RDARR, 16'hffe0, 8'h00, res);
    `FRC_CHK(res, 2'b10)
    i_pgm.sendId(8'hff);
    i_pgm.issue(frc_pkg::FRC_CMD_RDARR, 16'hffe0, 8'h00, res);
    `FRC_CHK(res, 2'b01)
    `FRC_CHK(pgmRdData, 8'hff)
    i_pgm.sendId(8'h00);
    i_pgm.issue(frc_pkg::FRC_CMD_RDARR, 16'hffe0, 8'h00, res);
    `FRC_CHK(res, 2'b10)
    i_pgm.sendId(8'hff);
    // option byte sets parallel protection; serial erase of its block clears it
    pgmMode <= 2'b00;
    cmd(frc_pkg::FRC_CMD_PROG, 16'hffff, 8'hf7);
    waitRdy();
    rd(`FRC_REG_INFO, v, r);
    `FRC_CHK(v[0], 1'b1)
    pgmMode <= 2'b10;
    i_pgm.issue(frc_pkg::FRC_CMD_RDARR, 16'hffff, 8'h00, res);
    `FRC_CHK(res, 2'b10)
    i_pgm.issue(frc_pkg::FRC_CMD_PROG, 16'h0020, 8'h00, res);
    `FRC_CHK(res, 2'b10)
    pgmMode <= 2'b01;
    i_pgm.issue(frc_pkg::FRC_CMD_ERASE, 16'hffc0, 8'h00, res);
    `FRC_CHK(res, 2'b01)
    rd(`FRC_REG_INFO, v, r);
    `FRC_CHK({v[3], v[0]}, 2'b10)
    pgmMode <= 2'b10;
    i_pgm.issue(frc_pkg::FRC_CMD_RDARR, 16'hffff, 8'h00, res);
    `FRC_CHK(res, 2'b01)
    `FRC_CHK(pgmRdData, 8'hff)
    // mid-run reset: registers clear, flash contents stay
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`FRC_REG_FCRA, v, r);
    `FRC_CHK(v, 32'h00000001)
    rd(`FRC_REG_INFO, v, r);
    `FRC_CHK(v[3:0], 4'hc)
    give_verdict();
  end
endmodule : flash_rewrite_control_test
